/* ptc_params.svh */
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PTC_OFS_LOWER_CTRL 8'h00
`define PTC_OFS_UPPER_CTRL 8'h04
`define PTC_OFS_LOWER_COUNT 8'h08
`define PTC_OFS_UPPER_COUNT 8'h0C
`define PTC_OFS_LOWER_PERIOD 8'h10
`define PTC_OFS_UPPER_PERIOD 8'h14
`define PTC_OFS_INT_STATUS 8'h18
`define PTC_OFS_INT_MASK 8'h1C

// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define PTC_BIT_RUN 15
`define PTC_BIT_IDLE_HALT 13
`define PTC_BIT_GATE 6
`define PTC_BIT_PS_HI 5
`define PTC_BIT_PS_LO 4
`define PTC_BIT_PAIR 3
`define PTC_BIT_CLKSRC 1

// ----------------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------------
`define PTC_INT_LOWER 0
`define PTC_INT_UPPER 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PTC_RST_CTRL 16'h0000
`define PTC_RST_COUNT 16'h0000
`define PTC_RST_PERIOD 16'hFFFF
`define PTC_RST_INT 2'h0

// ----------------------------------------------------------------------------
// prescaler terminal counts (ratio minus one)
// ----------------------------------------------------------------------------
`define PTC_TERM_DIV1 8'h00
`define PTC_TERM_DIV8 8'h07
`define PTC_TERM_DIV64 8'h3F
`define PTC_TERM_DIV256 8'hFF

`endif

/* ptc_pkg.sv */
`include "ptc_params.svh"

package ptc_pkg;

    // prescale select encodings
    typedef enum logic [1:0]
    {
        PTC_PS_DIV1 = 2'h0,
        PTC_PS_DIV8 = 2'h1,
        PTC_PS_DIV64 = 2'h2,
        PTC_PS_DIV256 = 2'h3
    } ptc_prescale_type;

    // decoded control fields of one timer
    typedef struct packed
    {
        logic timer_run;
        logic idle_halt;
        logic gate_accumulate;
        ptc_prescale_type prescale_select;
        logic wide_pair_select;
        logic clock_source_select;
    } ptc_ctrl_type;

    // register bus request
    typedef struct packed
    {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ptc_bus_req_type;

    // terminal count of the prescaler for a select code
    function automatic logic [7:0] ptc_term(input ptc_prescale_type ps);
        logic [7:0] t;
        t = `PTC_TERM_DIV1;
        unique case (ps)
            PTC_PS_DIV1: t = `PTC_TERM_DIV1;
            PTC_PS_DIV8: t = `PTC_TERM_DIV8;
            PTC_PS_DIV64: t = `PTC_TERM_DIV64;
            PTC_PS_DIV256: t = `PTC_TERM_DIV256;
        endcase
        return t;
    endfunction

endpackage

/* ptc_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none

// count-enable source: clock select, gating, idle halt and prescaler
module ptc_tick_gen
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire ptc_pkg::ptc_ctrl_type ctrl_in,
    input wire logic ext_clock_pin_in,
    input wire logic gate_in,
    input wire logic idle_mode_in,
    output logic tick_out
);
    import ptc_pkg::*;

    logic [7:0] pre_reg;
    logic [7:0] pre_next;
    logic pin_prev_reg;
    logic pin_prev_next;
    logic src_event;
    logic enable;
    logic tick;

    // source event, enable and prescaler next state
    always_comb
    begin
        pin_prev_next = ext_clock_pin_in;
        src_event = ctrl_in.clock_source_select ?
            (ext_clock_pin_in & ~pin_prev_reg) : 1'b1;
        enable = ctrl_in.timer_run
            & ~(idle_mode_in & ctrl_in.idle_halt)
            & (ctrl_in.clock_source_select
               | ~ctrl_in.gate_accumulate
               | gate_in);
        pre_next = pre_reg;
        tick = 1'b0;
        if (!ctrl_in.timer_run)
        begin
            pre_next = 8'h00;
        end
        else if (src_event && enable)
        begin
            if (pre_reg >= ptc_term(ctrl_in.prescale_select))
            begin
                pre_next = 8'h00;
                tick = 1'b1;
            end
            else
            begin
                pre_next = pre_reg + 8'h01;
            end
        end
    end

    // register stage
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pre_reg <= 8'h00;
            pin_prev_reg <= 1'b0;
        end
        else
        begin
            pre_reg <= pre_next;
            pin_prev_reg <= pin_prev_next;
        end
    end

    assign tick_out = tick;

    // checks
    property p_gate_hold;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (!ctrl_in.clock_source_select && ctrl_in.gate_accumulate && !gate_in) |-> !tick_out;
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("tick while gate low");

    property p_ext_edge;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ctrl_in.clock_source_select && tick_out) |-> (ext_clock_pin_in && !pin_prev_reg);
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("ext tick without rising edge");

    property p_ext_no_gate;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ctrl_in.timer_run && ctrl_in.clock_source_select && ctrl_in.gate_accumulate
         && !gate_in && !idle_mode_in && ctrl_in.prescale_select == PTC_PS_DIV1
         && ext_clock_pin_in && !pin_prev_reg) |-> tick_out;
    endproperty
    a_ext_no_gate: assert property (p_ext_no_gate) else $error("gate applied on ext clock");

    property p_div8;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (tick_out && ctrl_in.prescale_select == PTC_PS_DIV8) |=>
            (!tick_out || ctrl_in.prescale_select != PTC_PS_DIV8) [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 wrong");

    property p_idle_halt;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (idle_mode_in && ctrl_in.idle_halt) |-> !tick_out;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("tick during idle halt");

endmodule

`default_nettype wire

/* ptc_timer_pair.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ptc_params.svh"

// Summary of operation
// - external clock selected makes the gate enable bit ignored.
// - internal clock: gate bit set enables gated accumulation, clear counts freely.
// - prescale field bits 5:4 divides by 256, 64, 8 or 1.
// - pairing bit 3 joins both timers into one 32-bit timer.
// - clock source bit 1 set counts rising edges of the external pin.
// - unimplemented control bits 14, 12:7, 2 and 0 (and bit 3 of upper control) read zero, writes ignored.
// - run bit 15 of upper control starts or stops the upper timer.
// - idle halt bit 13 stops the timer while the device idles.
// - paired mode uses lower control, clock and gate; interrupt on upper flag.
// - paired mode: upper registers hold high word, lower registers low word.
// - paired mode: run bit starts and stops the 32-bit timer.
module ptc_timer_pair
#(
    parameter int DATA_W = 16
)
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire ptc_pkg::ptc_bus_req_type bus_in,
    output logic [15:0] rdata_out,
    input wire logic lower_ext_clock_pin_in,
    input wire logic upper_ext_clock_pin_in,
    input wire logic lower_gate_in,
    input wire logic upper_gate_in,
    input wire logic idle_mode_in,
    output logic irq_out
);
    import ptc_pkg::*;

    // ------------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------------
    if (DATA_W != 16)
    begin : g_bad_width
        $error("DATA_W must be 16");
    end

    ptc_ctrl_type lo_ctrl_reg;
    ptc_ctrl_type lo_ctrl_next;
    ptc_ctrl_type hi_ctrl_reg;
    ptc_ctrl_type hi_ctrl_next;
    logic [15:0] lo_cnt_reg;
    logic [15:0] lo_cnt_next;
    logic [15:0] hi_cnt_reg;
    logic [15:0] hi_cnt_next;
    logic [15:0] lo_per_reg;
    logic [15:0] lo_per_next;
    logic [15:0] hi_per_reg;
    logic [15:0] hi_per_next;
    logic [1:0] int_stat_reg;
    logic [1:0] int_stat_next;
    logic [1:0] int_mask_reg;
    logic [1:0] int_mask_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic tick_lo;
    logic tick_hi;
    logic ev_lo;
    logic ev_hi;
    logic paired;
    logic wr_en;
    logic [31:0] wide_cnt;
    logic [31:0] wide_per;

    // ------------------------------------------------------------------------
    // field packing helpers
    // ------------------------------------------------------------------------
    function automatic ptc_ctrl_type unpack_ctrl(input logic [15:0] d, input logic has_pair);
        ptc_ctrl_type c;
        c.timer_run = d[`PTC_BIT_RUN];
        c.idle_halt = d[`PTC_BIT_IDLE_HALT];
        c.gate_accumulate = d[`PTC_BIT_GATE];
        c.prescale_select = ptc_prescale_type'(d[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO]);
        c.wide_pair_select = has_pair & d[`PTC_BIT_PAIR];
        c.clock_source_select = d[`PTC_BIT_CLKSRC];
        return c;
    endfunction

    function automatic logic [15:0] pack_ctrl(input ptc_ctrl_type c);
        logic [15:0] d;
        d = 16'h0000; // unimplemented bits stay zero
        d[`PTC_BIT_RUN] = c.timer_run;
        d[`PTC_BIT_IDLE_HALT] = c.idle_halt;
        d[`PTC_BIT_GATE] = c.gate_accumulate;
        d[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO] = c.prescale_select;
        d[`PTC_BIT_PAIR] = c.wide_pair_select;
        d[`PTC_BIT_CLKSRC] = c.clock_source_select;
        return d;
    endfunction

    // ------------------------------------------------------------------------
    // count enable sources
    // ------------------------------------------------------------------------
    ptc_tick_gen u_tick_lo
    (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .ctrl_in(lo_ctrl_reg),
        .ext_clock_pin_in(lower_ext_clock_pin_in),
        .gate_in(lower_gate_in),
        .idle_mode_in(idle_mode_in),
        .tick_out(tick_lo)
    );

    ptc_tick_gen u_tick_hi
    (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .ctrl_in(hi_ctrl_reg),
        .ext_clock_pin_in(upper_ext_clock_pin_in),
        .gate_in(upper_gate_in),
        .idle_mode_in(idle_mode_in),
        .tick_out(tick_hi)
    );

    assign paired = lo_ctrl_reg.wide_pair_select;
    assign wide_cnt = {hi_cnt_reg, lo_cnt_reg};
    assign wide_per = {hi_per_reg, lo_per_reg};
    assign wr_en = bus_in.wr & ~bus_in.rd;

    // ------------------------------------------------------------------------
    // counters, registers and interrupt status next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        lo_ctrl_next = lo_ctrl_reg;
        hi_ctrl_next = hi_ctrl_reg;
        lo_cnt_next = lo_cnt_reg;
        hi_cnt_next = hi_cnt_reg;
        lo_per_next = lo_per_reg;
        hi_per_next = hi_per_reg;
        int_mask_next = int_mask_reg;
        ev_lo = 1'b0;
        ev_hi = 1'b0;
        if (paired)
        begin
            // one 32-bit timer driven by the lower source
            if (tick_lo)
            begin
                if (wide_cnt == wide_per)
                begin
                    {hi_cnt_next, lo_cnt_next} = 32'h0000_0000;
                    ev_hi = 1'b1;
                end
                else
                begin
                    {hi_cnt_next, lo_cnt_next} = wide_cnt + 32'h0000_0001;
                end
            end
        end
        else
        begin
            // two independent 16-bit timers
            if (tick_lo)
            begin
                lo_cnt_next = (lo_cnt_reg == lo_per_reg) ? 16'h0000 : lo_cnt_reg + 16'h0001;
                ev_lo = (lo_cnt_reg == lo_per_reg);
            end
            if (tick_hi)
            begin
                hi_cnt_next = (hi_cnt_reg == hi_per_reg) ? 16'h0000 : hi_cnt_reg + 16'h0001;
                ev_hi = (hi_cnt_reg == hi_per_reg);
            end
        end
        // software writes override the counting
        if (wr_en)
        begin
            unique case (bus_in.addr)
                `PTC_OFS_LOWER_CTRL: lo_ctrl_next = unpack_ctrl(bus_in.wdata, 1'b1);
                `PTC_OFS_UPPER_CTRL: hi_ctrl_next = unpack_ctrl(bus_in.wdata, 1'b0);
                `PTC_OFS_LOWER_COUNT: lo_cnt_next = bus_in.wdata;
                `PTC_OFS_UPPER_COUNT: hi_cnt_next = bus_in.wdata;
                `PTC_OFS_LOWER_PERIOD: lo_per_next = bus_in.wdata;
                `PTC_OFS_UPPER_PERIOD: hi_per_next = bus_in.wdata;
                `PTC_OFS_INT_MASK: int_mask_next = bus_in.wdata[1:0];
                default: ;
            endcase
        end
        // write one to clear; a new event wins over the clear
        int_stat_next = int_stat_reg;
        if (wr_en && bus_in.addr == `PTC_OFS_INT_STATUS)
        begin
            int_stat_next = int_stat_reg & ~bus_in.wdata[1:0];
        end
        int_stat_next[`PTC_INT_LOWER] = int_stat_next[`PTC_INT_LOWER] | ev_lo;
        int_stat_next[`PTC_INT_UPPER] = int_stat_next[`PTC_INT_UPPER] | ev_hi;
    end

    // ------------------------------------------------------------------------
    // read data, valid the cycle after the read strobe
    // ------------------------------------------------------------------------
    always_comb
    begin
        rdata_next = 16'h0000;
        if (bus_in.rd)
        begin
            unique case (bus_in.addr)
                `PTC_OFS_LOWER_CTRL: rdata_next = pack_ctrl(lo_ctrl_reg);
                `PTC_OFS_UPPER_CTRL: rdata_next = pack_ctrl(hi_ctrl_reg);
                `PTC_OFS_LOWER_COUNT: rdata_next = lo_cnt_reg;
                `PTC_OFS_UPPER_COUNT: rdata_next = hi_cnt_reg;
                `PTC_OFS_LOWER_PERIOD: rdata_next = lo_per_reg;
                `PTC_OFS_UPPER_PERIOD: rdata_next = hi_per_reg;
                `PTC_OFS_INT_STATUS: rdata_next = {14'h0000, int_stat_reg};
                `PTC_OFS_INT_MASK: rdata_next = {14'h0000, int_mask_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // register stage
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            lo_ctrl_reg <= ptc_ctrl_type'(7'h00);
            hi_ctrl_reg <= ptc_ctrl_type'(7'h00);
            lo_cnt_reg <= `PTC_RST_COUNT;
            hi_cnt_reg <= `PTC_RST_COUNT;
            lo_per_reg <= `PTC_RST_PERIOD;
            hi_per_reg <= `PTC_RST_PERIOD;
            int_stat_reg <= `PTC_RST_INT;
            int_mask_reg <= `PTC_RST_INT;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            lo_ctrl_reg <= lo_ctrl_next;
            hi_ctrl_reg <= hi_ctrl_next;
            lo_cnt_reg <= lo_cnt_next;
            hi_cnt_reg <= hi_cnt_next;
            lo_per_reg <= lo_per_next;
            hi_per_reg <= hi_per_next;
            int_stat_reg <= int_stat_next;
            int_mask_reg <= int_mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_out = rdata_reg;
    assign irq_out = |(int_stat_reg & int_mask_reg);

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    sequence s_ctrl_read;
        bus_in.rd && (bus_in.addr == `PTC_OFS_LOWER_CTRL || bus_in.addr == `PTC_OFS_UPPER_CTRL);
    endsequence

    property p_reserved_zero;
        @(posedge mclk_in) disable iff (!reset_n_in)
        s_ctrl_read |=> (rdata_out[14] == 1'b0 && rdata_out[12:7] == 6'h00
                         && rdata_out[2] == 1'b0 && rdata_out[0] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one");

    sequence s_wide_tick;
        paired && tick_lo && wide_cnt != wide_per;
    endsequence

    property p_wide_step;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (s_wide_tick ##0 !wr_en) |=> ({hi_cnt_reg, lo_cnt_reg} == $past(wide_cnt) + 32'h1);
    endproperty
    a_wide_step: assert property (p_wide_step) else $error("32-bit count did not step");

    property p_wide_hold;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (paired && !tick_lo && !wr_en) |=> $stable(wide_cnt);
    endproperty
    a_wide_hold: assert property (p_wide_hold) else $error("32-bit count moved idle");

    property p_wide_flag;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (paired && tick_lo && wide_cnt == wide_per && !wr_en) |=>
            (int_stat_reg[`PTC_INT_UPPER] && wide_cnt == 32'h0 && !$rose(int_stat_reg[`PTC_INT_LOWER]));
    endproperty
    a_wide_flag: assert property (p_wide_flag) else $error("32-bit match not on upper flag");

    property p_upper_stopped;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (!paired && !hi_ctrl_reg.timer_run && !wr_en) |=> $stable(hi_cnt_reg);
    endproperty
    a_upper_stopped: assert property (p_upper_stopped) else $error("stopped upper timer moved");

    property p_wide_stopped;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (paired && !lo_ctrl_reg.timer_run && !wr_en) [*2] |=> $stable(wide_cnt);
    endproperty
    a_wide_stopped: assert property (p_wide_stopped) else $error("stopped 32-bit timer moved");

    property p_set_wins;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ev_hi && wr_en && bus_in.addr == `PTC_OFS_INT_STATUS) |=> int_stat_reg[`PTC_INT_UPPER];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

    property p_irq_set;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ev_hi && int_mask_reg[`PTC_INT_UPPER]
         && !(wr_en && bus_in.addr == `PTC_OFS_INT_MASK)) |=> irq_out;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("upper match gave no interrupt");

endmodule

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ptc_params.svh"

module tb_top;
    import ptc_pkg::*;
    logic mclk_in;
    logic reset_n_in;
    ptc_bus_req_type bus;
    logic [15:0] rdata;
    logic lo_pin;
    logic up_pin;
    logic lo_gate;
    logic up_gate;
    logic idle;
    logic irq;
    logic [15:0] rd_val;
    int bad_count;
    int total_checks;
    int cycles;

    ptc_timer_pair #(.DATA_W(16)) ptc_timer_pair_inst
    (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .bus_in(bus),
        .rdata_out(rdata),
        .lower_ext_clock_pin_in(lo_pin),
        .upper_ext_clock_pin_in(up_pin),
        .lower_gate_in(lo_gate),
        .upper_gate_in(up_gate),
        .idle_mode_in(idle),
        .irq_out(irq)
    );

    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // cut the run short if the sequence hangs
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        #1;
        rd_val = rdata;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
        rd(a);
        check(rd_val, exp);
    endtask

    // interrupt pin, looked at once the edge's updates have settled
    task automatic chk_irq(input logic exp);
        #1;
        check({15'h0, irq}, {15'h0, exp});
    endtask

    // run taken at edge c0, stop taken at edge cn: n source events while running
    task automatic run_for(input logic [7:0] a, input logic [15:0] c, input int n);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: c, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        if (n > 1)
        begin
            bus.wr <= 1'b0;
            repeat (n - 1) @(posedge mclk_in);
        end
        bus <= '{addr: a, wdata: c & 16'h7FFF, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        chk_reg(`PTC_OFS_LOWER_CTRL, 16'h0000);
        chk_reg(`PTC_OFS_UPPER_PERIOD, 16'hFFFF);
        chk_reg(`PTC_OFS_INT_STATUS, 16'h0000);
        wr(`PTC_OFS_LOWER_CTRL, 16'hFFFF);
        wr(`PTC_OFS_UPPER_CTRL, 16'hFFFF);
        chk_reg(`PTC_OFS_LOWER_CTRL, 16'hA07A);
        chk_reg(`PTC_OFS_UPPER_CTRL, 16'hA072);
        wr(`PTC_OFS_UPPER_CTRL, 16'h0000);
        wr(`PTC_OFS_LOWER_CTRL, 16'h5F84);
        chk_reg(`PTC_OFS_LOWER_CTRL, 16'h0000);
        wr(8'h20, 16'h1234);
        chk_reg(8'h20, 16'h0000);
        $display("test regs done");
    endtask

    // upper timer alone, period 2, with the interrupt path
    task automatic t_upper();
        wr(`PTC_OFS_UPPER_PERIOD, 16'h0002);
        wr(`PTC_OFS_UPPER_COUNT, 16'h0000);
        run_for(`PTC_OFS_UPPER_CTRL, 16'h8000, 2);
        chk_reg(`PTC_OFS_UPPER_COUNT, 16'h0002);
        chk_reg(`PTC_OFS_INT_STATUS, 16'h0000);
        repeat (5) @(posedge mclk_in);
        chk_reg(`PTC_OFS_UPPER_COUNT, 16'h0002);
        run_for(`PTC_OFS_UPPER_CTRL, 16'h8000, 1);
        chk_reg(`PTC_OFS_UPPER_COUNT, 16'h0000);
        chk_reg(`PTC_OFS_INT_STATUS, 16'h0002);
        check({15'h0, irq}, 16'h0000);
        wr(`PTC_OFS_INT_MASK, 16'h0002);
        chk_irq(1'b1);
        wr(`PTC_OFS_INT_STATUS, 16'h0002);
        chk_reg(`PTC_OFS_INT_STATUS, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        // period 0 matches on every tick: a clear in mid-run loses to the set
        wr(`PTC_OFS_UPPER_PERIOD, 16'h0000);
        wr(`PTC_OFS_UPPER_CTRL, 16'h8000);
        wr(`PTC_OFS_INT_STATUS, 16'h0002);
        wr(`PTC_OFS_UPPER_CTRL, 16'h0000);
        chk_reg(`PTC_OFS_INT_STATUS, 16'h0002);
        $display("test upper done");
    endtask

    // every prescale code on the lower timer
    task automatic t_prescale();
        int divs[4] = '{1, 8, 64, 256};
        int m;
        for (int ps = 0; ps < 4; ps++)
        begin
            m = 10 * divs[ps] + divs[ps] / 2;
            wr(`PTC_OFS_LOWER_COUNT, 16'h0000);
            run_for(`PTC_OFS_LOWER_CTRL, 16'h8000 | 16'(ps << 4), m);
            chk_reg(`PTC_OFS_LOWER_COUNT, 16'(m / divs[ps]));
        end
        $display("test prescale done");
    endtask

    task automatic t_gate();
        lo_gate <= 1'b0;
        wr(`PTC_OFS_LOWER_COUNT, 16'h0000);
        run_for(`PTC_OFS_LOWER_CTRL, 16'h8040, 20);
        chk_reg(`PTC_OFS_LOWER_COUNT, 16'h0000);
        lo_gate <= 1'b1;
        run_for(`PTC_OFS_LOWER_CTRL, 16'h8040, 10);
        chk_reg(`PTC_OFS_LOWER_COUNT, 16'h000A);
        lo_gate <= 1'b0;
        run_for(`PTC_OFS_LOWER_CTRL, 16'h8000, 10);
        chk_reg(`PTC_OFS_LOWER_COUNT, 16'h0014);
        // external pin with gate bit set and gate input low
        wr(`PTC_OFS_LOWER_COUNT, 16'h0000);
        wr(`PTC_OFS_LOWER_CTRL, 16'h8042);
        repeat (5)
        begin
            @(posedge mclk_in);
            lo_pin <= 1'b1;
            repeat (2) @(posedge mclk_in);
            lo_pin <= 1'b0;
            @(posedge mclk_in);
        end
        repeat (3) @(posedge mclk_in);
        wr(`PTC_OFS_LOWER_CTRL, 16'h0000);
        chk_reg(`PTC_OFS_LOWER_COUNT, 16'h0005);
        $display("test gate done");
    endtask

    task automatic t_idle();
        idle <= 1'b1;
        wr(`PTC_OFS_LOWER_COUNT, 16'h0000);
        run_for(`PTC_OFS_LOWER_CTRL, 16'hA000, 20);
        chk_reg(`PTC_OFS_LOWER_COUNT, 16'h0000);
        run_for(`PTC_OFS_LOWER_CTRL, 16'h8000, 10);
        chk_reg(`PTC_OFS_LOWER_COUNT, 16'h000A);
        idle <= 1'b0;
        $display("test idle done");
    endtask

    // 32-bit pair: carry into the upper word, match on the upper flag
    task automatic t_pair();
        wr(`PTC_OFS_LOWER_COUNT, 16'hFFFE);
        wr(`PTC_OFS_UPPER_COUNT, 16'h0000);
        wr(`PTC_OFS_LOWER_PERIOD, 16'h0001);
        wr(`PTC_OFS_UPPER_PERIOD, 16'h0001);
        wr(`PTC_OFS_UPPER_CTRL, 16'h0030);
        wr(`PTC_OFS_INT_STATUS, 16'h0003);
        run_for(`PTC_OFS_LOWER_CTRL, 16'h8008, 3);
        chk_reg(`PTC_OFS_LOWER_COUNT, 16'h0001);
        chk_reg(`PTC_OFS_UPPER_COUNT, 16'h0001);
        chk_reg(`PTC_OFS_INT_STATUS, 16'h0000);
        run_for(`PTC_OFS_LOWER_CTRL, 16'h8008, 1);
        chk_reg(`PTC_OFS_UPPER_COUNT, 16'h0000);
        chk_reg(`PTC_OFS_INT_STATUS, 16'h0002);
        check({15'h0, irq}, 16'h0001);
        $display("test pair done");
    endtask

    // ------------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        reset_n_in = 1'b0;
        bus = '0;
        lo_pin = 1'b0;
        up_pin = 1'b0;
        lo_gate = 1'b0;
        up_gate = 1'b0;
        idle = 1'b0;
        repeat (6) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_upper();
        t_prescale();
        t_gate();
        t_idle();
        t_pair();
        conclude();
    end
endmodule

`default_nettype wire
